// file: dv/prc_top_tb.sv
// Self-checking bench for the peripheral reset and clock gate block
`timescale 1ns/1ns
module prc_top_tb
	import prc_pkg::*;
;
	logic                             aclk = 1'b0;
	logic                             aresetn;
	logic [ADDR_W-1:0]                s_axi_awaddr;
	logic [ADDR_W-1:0]                s_axi_araddr;
	logic                             s_axi_awvalid;
	logic                             s_axi_awready;
	logic [DATA_W-1:0]                s_axi_wdata;
	logic [3:0]                       s_axi_wstrb;
	logic                             s_axi_wvalid;
	logic                             s_axi_wready;
	logic [1:0]                       s_axi_bresp;
	logic                             s_axi_bvalid;
	logic                             s_axi_bready;
	logic                             s_axi_arvalid;
	logic                             s_axi_arready;
	logic [DATA_W-1:0]                s_axi_rdata;
	logic [1:0]                       s_axi_rresp;
	logic                             s_axi_rvalid;
	logic                             s_axi_rready;
	logic                             sleep_mode;
	prc_fast_s                        fast_rst;
	prc_slow_s                        slow_rst;
	logic [N_GATED-1:0]               gated_clk;
	logic [N_RDPATH-1:0][DATA_W-1:0]  periph_rdata;
	logic [N_RDPATH-1:0][DATA_W-1:0]  periph_rdata_gated;
	int                               miscompares = 0;
	int                               num_checks = 0;

	always #5 aclk = ~aclk;

	prc_top i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .sleep_mode(sleep_mode),
		.fast_rst(fast_rst), .slow_rst(slow_rst), .gated_clk(gated_clk),
		.periph_rdata(periph_rdata),
		.periph_rdata_gated(periph_rdata_gated)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes decided at the falling edge, where every input is settled
	task automatic axi_write(input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw;
		logic w;
		logic b;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(negedge aclk);
	endtask

	task automatic axi_read(input logic [ADDR_W-1:0] a,
		output logic [31:0] d, output logic [1:0] r);
		logic ar;
		logic rv;
		rv = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rv) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	// High phase must show exactly the enables, low phase nothing
	task automatic chk_clk(input logic [9:0] en);
		logic [9:0] hi;
		logic [9:0] lo;
		repeat (3) @(posedge aclk);
		#2 hi = gated_clk;
		@(negedge aclk);
		#2 lo = gated_clk;
		chk({22'h0, hi}, {22'h0, en});
		chk({22'h0, lo}, 32'h0);
		for (int i = 0; i < N_RDPATH; i++)
			chk(periph_rdata_gated[i], en[i] ? periph_rdata[i] : 32'h0);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, 4'hF, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		chk(d, e);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		rd(OFS_FAST_RST, 32'h0);
		rd(OFS_SLOW_RST, 32'h0);
		rd(OFS_SYS_CEN, 32'h4);
		rd(OFS_FAST_CEN, 32'h0);
		chk({24'h0, fast_rst}, 32'h0);
		chk({28'h0, slow_rst}, 32'h0);
		chk_clk(10'h200);
	endtask

	task automatic t_fast_rst();
		wr(OFS_FAST_RST, 32'hFFFFFFFF);
		rd(OFS_FAST_RST, 32'h5A35);
		chk({24'h0, fast_rst}, 32'hFF);
		wr(OFS_FAST_RST, 32'h4824);
		chk({24'h0, fast_rst}, 32'hAA);
		wr(OFS_FAST_RST, 32'h1211);
		repeat (20) @(posedge aclk);
		chk({24'h0, fast_rst}, 32'h55);
		wr(OFS_FAST_RST, 32'h0);
		chk({24'h0, fast_rst}, 32'h0);
	endtask

	// Byte lanes, then an address that decodes to nothing
	task automatic t_strobe_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		axi_write(OFS_FAST_RST, 32'hFFFFFFFF, 4'h2, r);
		chk({24'h0, fast_rst}, 32'hF0);
		rd(OFS_FAST_RST, 32'h5A00);
		wr(OFS_FAST_RST, 32'h0);
		axi_write(8'h1C, 32'hFFFFFFFF, 4'hF, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_read(8'h1C, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0);
		rd(OFS_SLOW_RST, 32'h0);
	endtask

	task automatic t_slow_rst();
		wr(OFS_SLOW_RST, 32'hFFFFFFFF);
		rd(OFS_SLOW_RST, 32'h10200801);
		chk({28'h0, slow_rst}, 32'hF);
		wr(OFS_SLOW_RST, 32'h10000800);
		chk({28'h0, slow_rst}, 32'hA);
		wr(OFS_SLOW_RST, 32'h00200001);
		chk({28'h0, slow_rst}, 32'h5);
		wr(OFS_SLOW_RST, 32'h0);
		chk({28'h0, slow_rst}, 32'h0);
	endtask

	task automatic t_fast_clk();
		wr(OFS_FAST_CEN, 32'hFFFFFFFF);
		rd(OFS_FAST_CEN, 32'h5A35);
		chk_clk(10'h2FF);
		wr(OFS_FAST_CEN, 32'h4824);
		chk_clk(10'h2AA);
		wr(OFS_FAST_CEN, 32'h1211);
		chk_clk(10'h255);
		wr(OFS_FAST_CEN, 32'h0);
		chk_clk(10'h200);
	endtask

	task automatic t_sys_clk();
		wr(OFS_SYS_CEN, 32'hFFFFFFFF);
		rd(OFS_SYS_CEN, 32'h5);
		chk_clk(10'h300);
		@(posedge aclk);
		sleep_mode <= 1'b1;
		chk_clk(10'h300);
		wr(OFS_SYS_CEN, 32'h1);
		chk_clk(10'h100);
		@(posedge aclk);
		sleep_mode <= 1'b0;
		chk_clk(10'h300);
		wr(OFS_SYS_CEN, 32'h0);
		chk_clk(10'h200);
		wr(OFS_SYS_CEN, 32'h4);
	endtask

	// Second reset in mid-run must restore every default
	task automatic t_mid_reset();
		wr(OFS_FAST_RST, 32'hFFFFFFFF);
		wr(OFS_FAST_CEN, 32'hFFFFFFFF);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_vals();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		sleep_mode = 1'b0;
		for (int i = 0; i < N_RDPATH; i++)
			periph_rdata[i] = 32'hC0DE0000 + 32'(i);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_vals();
		t_fast_rst();
		t_strobe_unmapped();
		t_slow_rst();
		t_fast_clk();
		t_sys_clk();
		t_mid_reset();
		final_report();
	end

	// Whole run is a few hundred cycles; this allows ample margin
	initial begin
		#300000;
		miscompares++;
		$display("[ERR] %0t run did not finish", $time);
		final_report();
	end

endmodule

// file: rtl/prc_clk_gate.sv
// Glitch-free clock gate: enable retimed on the falling edge
`timescale 1ns/1ns
module prc_clk_gate (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic en,
	output wire logic gclk
);

	logic en_r;

	// Enable only moves while aclk is low, so no pulse is ever cut short
	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			en_r <= 1'b0;
		end else begin
			en_r <= en;
		end
	end

	assign gclk = aclk & en_r;

endmodule

// file: rtl/prc_pkg.sv
// Shared constants and field layouts for the peripheral reset and clock gate
package prc_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned N_FAST   = 8;
	localparam int unsigned N_GATED  = 10;
	localparam int unsigned N_RDPATH = 9;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_FAST_RST = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SLOW_RST = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SYS_CEN  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_FAST_CEN = 8'h18;

	////////////////////////////////////////////////////////////////////////
	// Implemented bits; everything else reads as zero
	localparam logic [DATA_W-1:0] FAST_MASK = 32'h0000_5A35;
	localparam logic [DATA_W-1:0] SLOW_MASK = 32'h1020_0801;
	localparam logic [DATA_W-1:0] SYS_MASK  = 32'h0000_0005;

	localparam logic [DATA_W-1:0] FAST_RST_INIT = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SLOW_RST_INIT = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SYS_CEN_INIT  = 32'h0000_0004;
	localparam logic [DATA_W-1:0] FAST_CEN_INIT = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned BIT_SERIAL    = 14;
	localparam int unsigned BIT_SPI       = 12;
	localparam int unsigned BIT_ADV_TIMER = 11;
	localparam int unsigned BIT_CONVERTER = 9;
	localparam int unsigned BIT_PORT_D    = 5;
	localparam int unsigned BIT_PORT_C    = 4;
	localparam int unsigned BIT_PORT_A    = 2;
	localparam int unsigned BIT_ALT_FUNC  = 0;
	localparam int unsigned BIT_POWER     = 28;
	localparam int unsigned BIT_TWO_WIRE  = 21;
	localparam int unsigned BIT_WATCHDOG  = 11;
	localparam int unsigned BIT_GEN_TIMER = 0;
	localparam int unsigned BIT_RAM_KEEP  = 2;
	localparam int unsigned BIT_DMA       = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic serial;
		logic spi;
		logic adv_timer;
		logic converter;
		logic port_d;
		logic port_c;
		logic port_a;
		logic alt_function;
	} prc_fast_s;

	typedef struct packed {
		logic power;
		logic two_wire;
		logic watchdog;
		logic gen_timer;
	} prc_slow_s;

	function automatic prc_fast_s prc_fast_fields(
		input logic [DATA_W-1:0] w
	);
		prc_fast_s f;
		f.serial       = w[BIT_SERIAL];
		f.spi          = w[BIT_SPI];
		f.adv_timer    = w[BIT_ADV_TIMER];
		f.converter    = w[BIT_CONVERTER];
		f.port_d       = w[BIT_PORT_D];
		f.port_c       = w[BIT_PORT_C];
		f.port_a       = w[BIT_PORT_A];
		f.alt_function = w[BIT_ALT_FUNC];
		return f;
	endfunction

endpackage

// file: rtl/prc_top.sv
// Peripheral reset and clock gating registers behind an AXI4-Lite slave
//
// Overview of operation
// - Fast-bus reset bits 14, 12, 11 reset serial port, SPI, advanced timer.
// - Fast-bus reset bit 9 holds converter logic in reset while set.
// - Fast-bus reset bits 5, 4, 2 reset ports D, C and A.
// - Fast-bus reset bit 0 resets the alternate-function module.
// - Slow-bus reset bits 28 and 21 reset power interface and two-wire bus.
// - Slow-bus reset bits 11 and 0 reset window watchdog and timer 2.
// - System enable bit 2 resets to 1; keeps RAM clock in Sleep.
// - System enable bit 0 switches the DMA clock; resets to 0.
// - Reads of a peripheral with clock disabled return zero.
// - Fast-bus enable bits 14, 12, 11 gate serial, SPI, timer clocks.
// - Fast-bus enable bit 9 gates the converter clock; resets to 0.
// - Fast-bus enable bits 5, 4, 2 gate port D, C, A clocks.
// - Fast-bus enable bit 0 gates alternate-function clock; resets 0.
`timescale 1ns/1ns
module prc_top
	import prc_pkg::*;
(
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
	input  wire logic [2:0]                   s_axi_awprot,
	input  wire logic                         s_axi_awvalid,
	output wire logic                         s_axi_awready,
	input  wire logic [DATA_W-1:0]            s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output wire logic                         s_axi_wready,
	output wire logic [1:0]                   s_axi_bresp,
	output wire logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [ADDR_W-1:0]            s_axi_araddr,
	input  wire logic [2:0]                   s_axi_arprot,
	input  wire logic                         s_axi_arvalid,
	output wire logic                         s_axi_arready,
	output wire logic [DATA_W-1:0]            s_axi_rdata,
	output wire logic [1:0]                   s_axi_rresp,
	output wire logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         sleep_mode,
	output wire prc_fast_s                    fast_rst,
	output wire prc_slow_s                    slow_rst,
	output wire logic [N_GATED-1:0]           gated_clk,
	input  wire logic [N_RDPATH-1:0][DATA_W-1:0] periph_rdata,
	output wire logic [N_RDPATH-1:0][DATA_W-1:0] periph_rdata_gated
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [DATA_W-1:0] fast_rst_r;
	logic [DATA_W-1:0] slow_rst_r;
	logic [DATA_W-1:0] sys_cen_r;
	logic [DATA_W-1:0] fast_cen_r;

	logic              aw_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic              w_full_r;
	logic [DATA_W-1:0] w_data_r;
	logic [3:0]        w_strb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [1:0]        rresp_r;
	logic [DATA_W-1:0] rdata_r;

	function automatic logic [DATA_W-1:0] merge_strb(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0]        strb,
		input logic [DATA_W-1:0] mask
	);
		logic [DATA_W-1:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return ((old_v & ~lanes) | (new_v & lanes)) & mask;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire do_wr   = aw_full_r & w_full_r & ~bvalid_r;

	wire hit_fast_rst = aw_addr_r == OFS_FAST_RST;
	wire hit_slow_rst = aw_addr_r == OFS_SLOW_RST;
	wire hit_sys_cen  = aw_addr_r == OFS_SYS_CEN;
	wire hit_fast_cen = aw_addr_r == OFS_FAST_CEN;
	wire wr_mapped    = hit_fast_rst | hit_slow_rst | hit_sys_cen |
	                    hit_fast_cen;

	assign s_axi_awready = ~aw_full_r & ~bvalid_r;
	assign s_axi_wready  = ~w_full_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (aw_take) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (w_take) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (do_wr) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Bits are plain storage: a 1 holds reset until a 0 is written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_rst_r <= FAST_RST_INIT;
			slow_rst_r <= SLOW_RST_INIT;
			sys_cen_r  <= SYS_CEN_INIT;
			fast_cen_r <= FAST_CEN_INIT;
		end else if (do_wr) begin
			if (hit_fast_rst) begin
				fast_rst_r <= merge_strb(fast_rst_r, w_data_r, w_strb_r,
				                         FAST_MASK);
			end
			if (hit_slow_rst) begin
				slow_rst_r <= merge_strb(slow_rst_r, w_data_r, w_strb_r,
				                         SLOW_MASK);
			end
			if (hit_sys_cen) begin
				sys_cen_r <= merge_strb(sys_cen_r, w_data_r, w_strb_r,
				                        SYS_MASK);
			end
			if (hit_fast_cen) begin
				fast_cen_r <= merge_strb(fast_cen_r, w_data_r, w_strb_r,
				                         FAST_MASK);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	wire ar_take = s_axi_arvalid & s_axi_arready;

	wire rd_fast_rst = s_axi_araddr == OFS_FAST_RST;
	wire rd_slow_rst = s_axi_araddr == OFS_SLOW_RST;
	wire rd_sys_cen  = s_axi_araddr == OFS_SYS_CEN;
	wire rd_fast_cen = s_axi_araddr == OFS_FAST_CEN;
	wire rd_mapped   = rd_fast_rst | rd_slow_rst | rd_sys_cen | rd_fast_cen;

	wire [DATA_W-1:0] rd_mux =
		({DATA_W{rd_fast_rst}} & fast_rst_r) |
		({DATA_W{rd_slow_rst}} & slow_rst_r) |
		({DATA_W{rd_sys_cen}}  & sys_cen_r)  |
		({DATA_W{rd_fast_cen}} & fast_cen_r);

	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= '0;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			rdata_r  <= rd_mux;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset outputs, straight from the stored bits
	assign fast_rst = prc_fast_fields(fast_rst_r);
	assign slow_rst.power     = slow_rst_r[BIT_POWER];
	assign slow_rst.two_wire  = slow_rst_r[BIT_TWO_WIRE];
	assign slow_rst.watchdog  = slow_rst_r[BIT_WATCHDOG];
	assign slow_rst.gen_timer = slow_rst_r[BIT_GEN_TIMER];

	////////////////////////////////////////////////////////////////////////
	// Clock enables and gates
	wire prc_fast_s fast_on = prc_fast_fields(fast_cen_r);
	wire dma_clock_on         = sys_cen_r[BIT_DMA];
	wire ram_sleep_clock_keep = sys_cen_r[BIT_RAM_KEEP];
	wire ram_clk_run          = ram_sleep_clock_keep | ~sleep_mode;

	// Index 8 DMA, index 9 RAM interface; RAM has no read path here
	wire [N_GATED-1:0] gate_en = {ram_clk_run, dma_clock_on, fast_on};

	genvar gi;
	generate
		for (gi = 0; gi < N_GATED; gi++) begin : g_gate
			prc_clk_gate u_gate (
				.aclk    (aclk),
				.aresetn (aresetn),
				.en      (gate_en[gi]),
				.gclk    (gated_clk[gi])
			);
		end
	endgenerate

	// Read data of an unclocked peripheral is forced to zero
	logic [N_RDPATH-1:0][DATA_W-1:0] rd_gated_r;

	generate
		for (gi = 0; gi < N_RDPATH; gi++) begin : g_rdmask
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					rd_gated_r[gi] <= '0;
				end else begin
					rd_gated_r[gi] <= gate_en[gi] ? periph_rdata[gi] :
					                  '0;
				end
			end
		end
	endgenerate

	assign periph_rdata_gated = rd_gated_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Response raised and both address and data refused while it waits
	sequence s_resp_pending;
		bvalid_r && !s_axi_awready && !s_axi_wready;
	endsequence

	property p_fast_rst_set;
		@(posedge aclk) disable iff (!aresetn)
		do_wr && hit_fast_rst && w_strb_r[1] && w_data_r[BIT_SERIAL]
		|=> fast_rst.serial && fast_rst_r[BIT_SERIAL];
	endproperty
	a_fast_rst_set: assert property (p_fast_rst_set)
		else $error("serial reset not raised by write of 1");

	property p_converter_hold;
		@(posedge aclk) disable iff (!aresetn)
		fast_rst.converter && !(do_wr && hit_fast_rst) |=>
		fast_rst.converter;
	endproperty
	a_converter_hold: assert property (p_converter_hold)
		else $error("converter reset dropped without a write");

	property p_port_rst_map;
		@(posedge aclk) disable iff (!aresetn)
		do_wr && hit_fast_rst && w_strb_r[0] |=>
		fast_rst.port_d == $past(w_data_r[BIT_PORT_D]) &&
		fast_rst.port_c == $past(w_data_r[BIT_PORT_C]) &&
		fast_rst.port_a == $past(w_data_r[BIT_PORT_A]) &&
		fast_rst.alt_function == $past(w_data_r[BIT_ALT_FUNC]);
	endproperty
	a_port_rst_map: assert property (p_port_rst_map)
		else $error("port reset outputs mismatch stored bits");

	property p_slow_rst_clear;
		@(posedge aclk) disable iff (!aresetn)
		do_wr && hit_slow_rst && w_strb_r == 4'hF && w_data_r == '0
		|=> !slow_rst.power && !slow_rst.two_wire && !slow_rst.watchdog
		&& !slow_rst.gen_timer;
	endproperty
	a_slow_rst_clear: assert property (p_slow_rst_clear)
		else $error("slow bus resets not released by write of 0");

	property p_ram_sleep;
		@(negedge aclk) disable iff (!aresetn)
		$past(sleep_mode) && !$past(sys_cen_r[BIT_RAM_KEEP]) |->
		!gated_clk[9];
	endproperty
	a_ram_sleep: assert property (p_ram_sleep)
		else $error("RAM clock enabled in Sleep without keep bit");

	property p_reset_values;
		@(posedge aclk)
		!aresetn |=> sys_cen_r == 32'h0000_0004 && fast_cen_r == '0 &&
		!dma_clock_on;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("enable registers wrong after reset");

	property p_rd_zero;
		@(posedge aclk) disable iff (!aresetn)
		!fast_cen_r[BIT_CONVERTER] && !(do_wr && hit_fast_cen) |=>
		periph_rdata_gated[4] == '0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("converter read data leaked while unclocked");

	// Sampled just before the fall, so the whole high phase is seen
	property p_gate_timing;
		@(negedge aclk) disable iff (!aresetn)
		gated_clk[0] == $past(gate_en[0]);
	endproperty
	a_gate_timing: assert property (p_gate_timing)
		else $error("alternate-function clock still running");

	property p_wr_resp;
		@(posedge aclk) disable iff (!aresetn)
		do_wr |=> s_resp_pending;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response missing after write");

	property p_rd_resp;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && rd_fast_cen |=> rvalid_r && rdata_r == $past(fast_cen_r);
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read data of enable register wrong");

endmodule
